// file: dst_pkg.sv
// shared types and constants for the sgi, status and capability register block
// Notes on behaviour
// - legacy trigger word at 0x0F00, write-only; reserved-zero while affinity routing enabled.
// - trigger writes act regardless of distributor forwarding enable; fixed choice.
// - setting a pending bit makes inactive pending, active becomes active-and-pending.
// - four 32-bit set-pending words, four byte fields, 16 interrupts, copy per element.
// - bit reads 1 when pending; writing 1 adds pending, writing 0 does nothing.
// - all set-pending fields reset to zero.
// - interrupt m from source C: word m/4 at 0xF20+4n, byte m%4, bit C.
// - affinity routing enabled for interrupt's security state makes its bits read zero.
// - unimplemented interrupt bits read zero, ignore writes; byte and word accesses accepted.
// - with two security states, group 0 and unimplemented-element bits hidden from non-secure.
// - flag bit3 write read-only, bit2 read write-only, bit1 reserved write, bit0 reserved read.
// - each flag stays set until software writes one to that bit.
// - with two security states the flags word at 0x0010 is banked secure/non-secure.
// - flags word optional; when absent it reads zero and ignores writes.
// - capability bits 31:27 give extended range size when present, else zero.
// - capability bit 26 reports affinity-0 range 0-15 or 0-255 support.
// - bit 25 set when one-of-n delivery absent; bit 24 set for nonzero affinity 3.
// - capability bits 23:19 hold interrupt identifier width minus one.
// - bit 18 direct virtual injection, bit 17 locality-specific interrupt support.
// - bit 16 reports message-based shared interrupt support.
// - bits 15:11 locality count, zero when identifier width below 14 bits.
// - bit 10 reports two security states, reads zero when security is disabled.
// - bit 8 reports extended shared range present, qualifying bits 31:27.
// - bits 4:0 hold n, max shared interrupt number 32(n+1)-1.
// - capability word read-only at 0x0004 for both security states.
package dst_pkg;

    localparam logic [15:0] OFF_CAPS = 16'h0004;
    localparam logic [15:0] OFF_FLAGS = 16'h0010;
    localparam logic [15:0] OFF_TRIG = 16'h0F00;
    localparam logic [15:0] OFF_SETPEND = 16'h0F20;
    localparam logic [15:0] SETPEND_IDX_MASK = 16'h000C;
    localparam logic [7:0] SETPEND_RST = 8'h00;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [4:0] LPI_MIN_ID_W_M1 = 5'h0D;
    localparam int SGI_MAX = 16;
    localparam int PE_MAX = 8;

    typedef enum logic [1:0] {
        FILT_LIST = 2'b00,
        FILT_OTHERS = 2'b01,
        FILT_SELF = 2'b10,
        FILT_RSVD = 2'b11
    } dst_filt_t;

    typedef struct packed {
        logic [5:0] rsvd_hi;
        dst_filt_t filt;
        logic [7:0] list;
        logic want_grp1;
        logic [10:0] rsvd_lo;
        logic [3:0] interrupt_number;
    } dst_trig_t;

    typedef struct packed {
        logic [27:0] rsvd;
        logic write_readonly_flag;
        logic read_writeonly_flag;
        logic write_reserved_flag;
        logic read_reserved_flag;
    } dst_flags_t;

    typedef struct packed {
        logic [4:0] extended_range_size;
        logic range_selector_support;
        logic one_of_n_absent;
        logic affinity3_valid;
        logic [4:0] id_width_minus_one;
        logic direct_virtual_inject;
        logic locality_irq_support;
        logic message_irq_support;
        logic [4:0] locality_irq_count;
        logic two_security_states;
        logic rsvd9;
        logic extended_range_present;
        logic [2:0] pe_count_minus_one;
        logic [4:0] shared_irq_lines;
    } dst_caps_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic secure;
        logic [2:0] pe;
        logic [15:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } dst_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } dst_rsp_t;

    typedef struct packed {
        logic valid;
        logic [2:0] pe;
        logic [3:0] sgi;
        logic [2:0] src;
    } dst_act_t;

endpackage

// file: dst_sgi_regs.sv
// sgi trigger, sgi set-pending, access flags and capability registers
`timescale 1ns/10ps
module dst_sgi_regs
    import dst_pkg::*;
#(
    parameter int NUM_PE = 8,
    parameter int NUM_SGI = 16,
    parameter bit TWO_SEC = 1'b1,
    parameter bit HAS_FLAGS = 1'b1,
    parameter bit EXTENDED_RANGE_PRESENT_EN = 1'b0,
    parameter logic [4:0] EXTENDED_RANGE_PRESENT_SIZE = 5'h00,
    parameter bit RSS_EN = 1'b0,
    parameter bit NO_ONE_OF_N = 1'b0,
    parameter bit AFF3_EN = 1'b0,
    parameter logic [4:0] ID_W_M1 = 5'h09,
    parameter bit DVI_EN = 1'b0,
    parameter bit LPI_EN = 1'b0,
    parameter bit MSG_EN = 1'b0,
    parameter logic [4:0] LPI_COUNT = 5'h00,
    parameter logic [4:0] SHARED_LINES = 5'h00
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // register access
    input wire dst_req_t req,
    output dst_rsp_t rsp,
    // distributor control state
    input wire logic disable_security,
    input wire logic are_secure,
    input wire logic are_nonsecure,
    // per target: sgi configured as group 0
    input wire logic [NUM_PE-1:0][15:0] sgi_group0,
    // activation from cpu interfaces
    input wire dst_act_t act,
    // pending state per target, sgi, source
    output logic [NUM_PE-1:0][15:0][7:0] sgi_pending
);

    localparam logic [7:0] SRC_MASK = 8'((16'h0001 << NUM_PE) - 16'h0001);

    logic [NUM_PE-1:0][15:0][7:0] pend_q, pend_d;
    dst_flags_t flags_q [2];
    dst_rsp_t rsp_q;
    logic [31:0] spend_rdata;
    logic [7:0] trig_targets;

    // security view of the current configuration
    wire logic two_sec = TWO_SEC & ~disable_security;
    wire logic are_any = are_secure | (two_sec & are_nonsecure);
    wire logic bank = two_sec & ~req.secure;

    // decode
    wire logic rd = req.valid & ~req.write;
    wire logic wr = req.valid & req.write;
    wire logic hit_caps = req.addr == OFF_CAPS;
    wire logic hit_flags = req.addr == OFF_FLAGS;
    wire logic hit_trig = req.addr == OFF_TRIG;
    wire logic hit_spend = (req.addr & ~SETPEND_IDX_MASK) == OFF_SETPEND;
    wire logic [1:0] spend_n = req.addr[3:2];
    wire logic pe_ok = 32'(req.pe) < NUM_PE;
    wire logic mapped = hit_caps | hit_flags | hit_trig | hit_spend;
    wire logic trig_rsvd = hit_trig & are_any;

    // access violation events, one per flag bit
    wire logic ev_wr_ro = wr & hit_caps;
    wire logic ev_rd_wo = rd & hit_trig & ~are_any;
    wire logic ev_wr_rsvd = wr & (~mapped | trig_rsvd);
    wire logic ev_rd_rsvd = rd & (~mapped | trig_rsvd);
    wire logic [3:0] ev = {ev_wr_ro, ev_rd_wo, ev_wr_rsvd, ev_rd_rsvd};
    wire logic [3:0] flag_clr = (wr & hit_flags & req.be[0]) ? req.wdata[3:0] : 4'h0;

    // legacy trigger word
    wire dst_trig_t trig = dst_trig_t'(req.wdata);
    wire logic trig_go = wr & hit_trig & ~are_any & pe_ok & (32'(trig.interrupt_number) < NUM_SGI);
    wire logic [7:0] self_mask = 8'h01 << req.pe;

    // capability word, set by parameters and by disable_security (bit 10)
    wire dst_caps_t caps = '{
        extended_range_size: EXTENDED_RANGE_PRESENT_EN ? EXTENDED_RANGE_PRESENT_SIZE : 5'h00,
        range_selector_support: RSS_EN,
        one_of_n_absent: NO_ONE_OF_N,
        affinity3_valid: AFF3_EN,
        id_width_minus_one: ID_W_M1,
        direct_virtual_inject: DVI_EN,
        locality_irq_support: LPI_EN,
        message_irq_support: MSG_EN,
        locality_irq_count: (ID_W_M1 >= LPI_MIN_ID_W_M1) ? LPI_COUNT : 5'h00,
        two_security_states: two_sec,
        rsvd9: 1'b0,
        extended_range_present: EXTENDED_RANGE_PRESENT_EN,
        pe_count_minus_one: 3'(NUM_PE - 1),
        shared_irq_lines: SHARED_LINES
    };

    wire logic [31:0] flags_rdata = HAS_FLAGS ? 32'(flags_q[bank]) : 32'h0000_0000;
    wire logic [31:0] rdata_mux =
        hit_caps ? 32'(caps) :
        hit_flags ? flags_rdata :
        hit_spend ? spend_rdata : 32'h0000_0000;

    // a set-pending bit is visible to this access
    function automatic logic sgi_visible(input logic grp0, input logic secure, input int sgi);
        logic are_own;
        are_own = (grp0 | ~two_sec) ? are_secure : are_nonsecure;
        return (sgi < NUM_SGI) && !are_own && !(two_sec && !secure && grp0);
    endfunction

    // group check for a trigger at one target
    function automatic logic trig_group_ok(input logic grp0);
        logic want1;
        want1 = req.secure ? trig.want_grp1 : 1'b1;
        return ~two_sec | (want1 ? ~grp0 : grp0);
    endfunction

    always_comb begin
        case (trig.filt)
            FILT_LIST: trig_targets = trig.list;
            FILT_OTHERS: trig_targets = SRC_MASK & ~self_mask;
            FILT_SELF: trig_targets = self_mask;
            default: trig_targets = 8'h00;
        endcase
    end

    // read view of the requester's copy
    always_comb begin
        spend_rdata = 32'h0000_0000;
        if (pe_ok) begin
            for (int x = 0; x < 4; x++) begin
                if (sgi_visible(sgi_group0[req.pe][4*spend_n+x], req.secure, 4*spend_n+x)) begin
                    spend_rdata[8*x +: 8] = pend_q[req.pe][4*spend_n+x] & SRC_MASK;
                end
            end
        end
    end

    // pending next state: activation clears, triggers and set-pending writes set; set wins
    always_comb begin
        pend_d = pend_q;
        if (act.valid && 32'(act.pe) < NUM_PE) begin
            pend_d[act.pe][act.sgi][act.src] = 1'b0;
        end
        for (int t = 0; t < NUM_PE; t++) begin
            if (trig_go && trig_targets[t] && trig_group_ok(sgi_group0[t][trig.interrupt_number])) begin
                pend_d[t][trig.interrupt_number][req.pe] = 1'b1;
            end
        end
        if (wr && hit_spend && pe_ok) begin
            for (int x = 0; x < 4; x++) begin
                if (req.be[x] && sgi_visible(sgi_group0[req.pe][4*spend_n+x], req.secure, 4*spend_n+x)) begin
                    pend_d[req.pe][4*spend_n+x] = pend_d[req.pe][4*spend_n+x]
                        | (req.wdata[8*x +: 8] & SRC_MASK);
                end
            end
        end
        for (int t = 0; t < NUM_PE; t++) begin
            for (int s = 0; s < SGI_MAX; s++) begin
                pend_d[t][s] = (s < NUM_SGI) ? (pend_d[t][s] & SRC_MASK) : SETPEND_RST;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int t = 0; t < NUM_PE; t++) begin
                for (int s = 0; s < SGI_MAX; s++) begin
                    pend_q[t][s] <= SETPEND_RST;
                end
            end
        end else if (ce) begin
            pend_q <= pend_d;
        end
    end

    // access flags, one copy per security bank
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags_q[0] <= dst_flags_t'(FLAGS_RST);
            flags_q[1] <= dst_flags_t'(FLAGS_RST);
        end else if (ce) begin
            for (int b = 0; b < 2; b++) begin
                if (HAS_FLAGS && bank == b[0]) begin
                    flags_q[b] <= dst_flags_t'({28'h000_0000, (flags_q[b][3:0] & ~flag_clr) | ev});
                end
            end
        end
    end

    // single-cycle answer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rsp_q <= '0;
        end else if (ce) begin
            rsp_q.ack <= req.valid;
            rsp_q.rdata <= rd ? rdata_mux : 32'h0000_0000;
        end
    end

    assign rsp = rsp_q;
    assign sgi_pending = pend_q;

endmodule

// file: dst_cpu_model.sv
// cpu interfaces that take pending sgis into service
`timescale 1ns/10ps
module dst_cpu_model
    import dst_pkg::*;
#(
    parameter int NUM_PE = 4
) (
    // control
    input wire logic clk,
    input wire logic go,
    // block side
    input wire logic [NUM_PE-1:0][15:0][7:0] sgi_pending,
    output dst_act_t act
);
    int n = 0;
    initial act = '0;
    // one activation every third cycle; idle fields keep changing
    always @(negedge clk) begin
        n++;
        act = '{1'b0, 3'(n), 4'(n), 3'(n)};
        for (int i = 0; i < NUM_PE * 128; i++) begin
            if (go && n % 3 == 0 && !act.valid && sgi_pending[i / 128][i / 8 % 16][i % 8]) begin
                act = '{1'b1, 3'(i / 128), 4'(i / 8), 3'(i)};
            end
        end
    end
endmodule

// file: dst_sgi_regs_asserts.sv
// concurrent checks on the sgi and capability registers
`timescale 1ns/10ps
module dst_sgi_regs_asserts
    import dst_pkg::*;
#(
    parameter int NUM_PE = 8
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // access
    input wire dst_req_t req,
    input wire dst_rsp_t rsp,
    // control
    input wire logic disable_security,
    input wire logic are_secure,
    input wire logic are_nonsecure,
    // pending state
    input wire dst_act_t act,
    input wire logic [NUM_PE-1:0][15:0][7:0] sgi_pending
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic rd = ce && req.valid && !req.write;
    wire logic wr = ce && req.valid && req.write;
    ack_after_req_a: assert property (ce && req.valid |=> rsp.ack)
        else $error("access not acked");
    no_stray_ack_a: assert property (ce && !req.valid |=> !rsp.ack)
        else $error("ack without access");
    caps_value_a: assert property (rd && req.addr == OFF_CAPS |=> rsp.rdata ==
        {8'h00, 5'h09, 8'h00, !$past(disable_security), 2'b00, 3'(NUM_PE - 1), 5'h00})
        else $error("capability word wrong");
    trig_reads_zero_a: assert property (rd && req.addr == OFF_TRIG |=> rsp.rdata == '0)
        else $error("trigger read not zero");
    write_rdata_a: assert property (wr |=> rsp.rdata == '0)
        else $error("write answered with data");
    pend_set_a: assert property (wr && req.secure && req.addr == OFF_SETPEND && req.be[0]
        && req.wdata[0] && req.pe < NUM_PE && !are_secure && !are_nonsecure
        |=> sgi_pending[$past(req.pe)][0][0])
        else $error("pending bit not set");
    no_drop_a: assert property (ce && !act.valid |=> ($past(sgi_pending) & ~sgi_pending) == '0)
        else $error("pending bit lost");
    act_clear_a: assert property (ce && act.valid && act.pe < NUM_PE && !wr
        |=> !sgi_pending[$past(act.pe)][$past(act.sgi)][$past(act.src)])
        else $error("activation kept pending");
    rst_clear_a: assert property (@(posedge clk) disable iff (1'b0) !rst_n |=> sgi_pending == '0 && !rsp.ack)
        else $error("reset state wrong");
endmodule
bind dst_sgi_regs dst_sgi_regs_asserts #(.NUM_PE(NUM_PE)) u_asserts (.clk(clk), .rst_n(rst_n), .ce(ce),
    .req(req), .rsp(rsp), .disable_security(disable_security), .are_secure(are_secure),
    .are_nonsecure(are_nonsecure), .act(act), .sgi_pending(sgi_pending));

// file: dst_sgi_regs_bench.sv
// self-checking bench for the sgi, flags and capability registers
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module dst_sgi_regs_bench;
    import dst_pkg::*;
    localparam int NP = 4;
    localparam logic [31:0] CAPS = 32'h0048_0460;
    logic clk = 1'b0;
    logic rst_n, ce, ds, ars, arn, go;
    logic [NP-1:0][15:0] grp0;
    logic [NP-1:0][15:0][7:0] pend, mdl;
    dst_req_t req;
    dst_rsp_t rsp;
    dst_act_t act;
    logic [31:0] seed = 32'h0000_0031;
    logic [31:0] r, got_e;
    logic [31:0] exp_q[$];
    int error_cnt = 0;
    int tests_run = 0;
    dst_sgi_regs #(.NUM_PE(NP)) dut (.clk(clk), .rst_n(rst_n), .ce(ce), .req(req), .rsp(rsp),
        .disable_security(ds), .are_secure(ars), .are_nonsecure(arn), .sgi_group0(grp0),
        .act(act), .sgi_pending(pend));
    dst_cpu_model #(.NUM_PE(NP)) cpu (.clk(clk), .go(go), .sgi_pending(pend), .act(act));
    initial forever #2.5 clk = ~clk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] spa(input logic [3:0] m);
        return OFF_SETPEND | {12'h000, m[3:2], 2'b00};
    endfunction
    function automatic logic [31:0] trg(input dst_filt_t f, input logic [7:0] l, input logic [3:0] id);
        return {6'h00, f, l, 1'b1, 11'h000, id};
    endfunction
    // request held until the next falling edge, so one rising edge takes it
    task automatic acc(input logic w, s, input logic [2:0] p, input logic [15:0] a,
            input logic [3:0] b, input logic [31:0] d, e);
        req <= '{1'b1, w, s, p, a, b, d};
        exp_q.push_back(e);
        @(negedge clk);
    endtask
    task automatic rel(input string msg);
        req.valid <= 1'b0;
        repeat (3) @(negedge clk);
        $display("test done: %s", msg);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(negedge clk) begin
        if (rsp.ack === 1'b1) begin
            got_e = exp_q.pop_front();
            `CHK(rsp.rdata, got_e)
        end
    end
    always @(posedge clk) if (act.valid === 1'b1) mdl[act.pe[1:0]][act.sgi][act.src] <= 1'b0;
    initial begin
        #200_000;
        error_cnt++;
        complete_run();
    end
    initial begin
        {rst_n, ds, ars, arn, go, grp0, mdl} = '0;
        ce = 1'b1;
        req = '0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        for (int n = 0; n < 4; n++) acc(0, 1, 0, spa(4'(4 * n)), 4'hF, 0, 0);
        acc(0, 1, 0, OFF_CAPS, 4'hF, 0, CAPS);
        acc(1, 1, 0, OFF_CAPS, 4'hF, '1, 0);
        ds = 1'b1;
        acc(0, 1, 0, OFF_CAPS, 4'hF, 0, CAPS & ~32'h400);
        ds = 1'b0;
        acc(0, 1, 0, OFF_FLAGS, 4'hF, 0, 32'h8);
        acc(0, 1, 0, OFF_TRIG, 4'hF, 0, 0);
        acc(0, 1, 0, 16'h0100, 4'hF, 0, 0);
        acc(1, 1, 0, 16'h0100, 4'hF, '1, 0);
        acc(0, 0, 0, OFF_FLAGS, 4'hF, 0, 0);
        acc(0, 1, 0, OFF_FLAGS, 4'hF, 0, 32'hF);
        acc(1, 1, 0, OFF_FLAGS, 4'h1, 32'h5, 0);
        acc(0, 1, 0, OFF_FLAGS, 4'hF, 0, 32'hA);
        acc(1, 1, 0, OFF_FLAGS, 4'h1, 32'hA, 0);
        rel("capabilities and flags");
        for (int k = 0; k < 40; k++) begin
            r = xs();
            acc(1, 1, {1'b0, r[1:0]}, spa(r[5:2]), 4'h1 << r[3:2], 32'h1 << {r[3:2], 1'b0, r[7:6]}, 0);
            mdl[r[1:0]][r[5:2]][r[7:6]] = 1'b1;
        end
        acc(1, 1, 5, spa(0), 4'hF, '1, 0);
        acc(1, 1, 0, spa(0), 4'hF, 32'hF0F0_F0F0, 0);
        acc(1, 1, 0, spa(0), 4'hF, 32'h0000_0001, 0);
        mdl[0][0][0] = 1'b1;
        grp0[1][0] = 1'b1;
        acc(1, 0, 1, spa(0), 4'h1, 32'hF, 0);
        arn = 1'b1;
        acc(1, 1, 2, spa(8), 4'hF, 32'h0F0F_0F0F, 0);
        arn = 1'b0;
        for (int i = 0; i < 16; i++) acc(0, 1, 3'(i / 4), spa(4'(4 * (i % 4))), 4'hF, 0,
            mdl[i / 4][4 * (i % 4) + 3 -: 4]);
        rel("set-pending");
        `CHK(pend, mdl)
        acc(1, 1, 2, OFF_TRIG, 4'hF, trg(FILT_SELF, 0, 9), 0);
        acc(1, 0, 1, OFF_TRIG, 4'hF, trg(FILT_LIST, 8'h09, 3), 0);
        acc(1, 1, 0, OFF_TRIG, 4'hF, trg(FILT_OTHERS, 0, 12), 0);
        acc(1, 1, 0, OFF_TRIG, 4'hF, trg(FILT_RSVD, '1, 7), 0);
        ars = 1'b1;
        acc(1, 1, 3, OFF_TRIG, 4'hF, trg(FILT_SELF, 0, 1), 0);
        ars = 1'b0;
        acc(0, 1, 0, OFF_FLAGS, 4'hF, 0, 32'h2);
        rel("trigger");
        mdl[2][9][2] = 1'b1;
        mdl[0][3][1] = 1'b1;
        mdl[3][3][1] = 1'b1;
        for (int t = 1; t < NP; t++) mdl[t][12][0] = 1'b1;
        `CHK(pend, mdl)
        go = 1'b1;
        for (int i = 0; i < 3000 && pend !== '0; i++) @(negedge clk);
        go = 1'b0;
        `CHK(pend, '0)
        acc(1, 1, 3, OFF_TRIG, 4'hF, trg(FILT_SELF, 0, 9), 0);
        rel("activation");
        `CHK(pend[3][9], 8'h08)
        `CHK(exp_q.size(), 0)
        complete_run();
    end
endmodule
